// *** apf_cfg.svh ***
// Purpose: Constants of the amplifier protection and fault monitor
// Assumes: 200 MHz system clock
// Notes:   Offsets are control-bus register indices
`ifndef APF_CFG_SVH
`define APF_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APF_REG_FAULT0 8'h00
`define APF_REG_FAULT1 8'h01
`define APF_REG_THERM 8'h04
`define APF_REG_GAIN 8'h05
`define APF_REG_CTRL 8'h0A
`define APF_REG_DCTIME 8'h0B
`define APF_REG_MODE 8'h0C
`define APF_REG_CMD 8'h0D
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define APF_THERM_WARN_LSB 5
`define APF_CMD_GLOBAL_BIT 4
`define APF_CTRL_DCSD_BIT 2
`define APF_CTRL_DCTH_LSB 3
`define APF_MODE_RST 4'hF
`define APF_GAIN_RST 8'h00
`define APF_CLIPSRC_RST 2'h1
`define APF_DCTIME_RST 8'h10
`define APF_ADDR_BASE 7'h6C
// ----------------------------------------
// Timing
// ----------------------------------------
`define APF_CLK_MHZ 200
`define APF_OC_STOP_MIN_US 200
`define APF_OC_STOP_MAX_US 390
`define APF_OC_STOP_CYCLES (`APF_OC_STOP_MIN_US * `APF_CLK_MHZ)
`define APF_OC_STOP_MAX_CYCLES (`APF_OC_STOP_MAX_US * `APF_CLK_MHZ)
`endif

// *** apf_host_model.sv ***
// Purpose: Controller side of the register byte port
// Assumes: Port is sampled on the rising edge of sys_clk
// Notes:   Strobes change on falling edges only, never mid-cycle
`timescale 1ns/10ps
module apf_host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    // Idle port at time zero
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    // ----------------------------------------
    // Byte transfers
    // ----------------------------------------
    // Write: strobe spans exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regWrData = ~d; // Stale data must not pass for a new write
    endtask : wr

    // Read: data is taken once the registered answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        @(negedge sys_clk);
        d = regRdData;
    endtask : rd
endmodule : apf_host_model

// *** apf_monitor.sv ***
// Purpose: Protection, fault latching and indicator pins of a 4-channel amp
// Assumes: Sense inputs are synchronous comparator outputs; registers
//          are reached through a byte port behind the control-bus engine
// Notes:   Faults latch until the clear command
// What this block does
// - Average overcurrent ends pulse, channel keeps playing
// - Held peak short stops only that channel
// - Overcurrent stop sets fault pin and bit
// - Restart command resumes a stopped channel
// - Brief peak short only limits current
// - Held dc offset raises a dc event
// - Dc event stops channel only when enabled
// - Clip pin follows any full-duty channel
// - Clip pin source selectable among four
// - Clip pin reports thermal warning after reset
// - Three warning levels with hysteresis in 0x04
// - Thermal shutdown mutes all, asserts fault
// - Warning holds until below level one
// - Foldback lowers channel gain
// - Supply low sets fault pin and bit
// - Power-on reset floats bus, clears setup
// - Supply high sets fault pin and bit
// - Per-channel gain 12, 20, 26, 32 dB
// - Mute register and separate fault-clear command
// - Address pin picks address and oscillator role
// - Align pin syncs or drives switching clock
// - All faults readable in registers
// - Faults force high impedance at once
`timescale 1ns/10ps
`include "apf_cfg.svh"
module apf_monitor import apf_pkg::*; #(
    parameter int OC_STOP_CYCLES = `APF_OC_STOP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port from the control-bus engine
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Per-channel sense
    input wire logic [3:0] avgOverCur,
    input wire logic [3:0] peakOverCur,
    input wire logic [3:0] dcOffsetHigh,
    input wire logic [3:0] fullDuty,
    input wire logic [3:0] tweetDetect,
    // Thermal sense
    input wire logic [2:0] tempAbove,
    input wire logic [2:0] tempBelowHyst,
    input wire logic tempShutdown,
    input wire logic tempFoldback,
    // Supply sense
    input wire logic powerStageLow,
    input wire logic analogSupplyLow,
    input wire logic chargePumpLow,
    input wire logic powerStageHigh,
    input wire logic porActive,
    // Address strap and oscillator alignment
    input wire logic [1:0] addrSel,
    input wire logic oscLocal,
    input wire logic oscAlignIn,
    output logic oscAlignOut,
    output logic oscAlignOe,
    output logic switchRef,
    // Channel control
    output logic [3:0] pulseEnd,
    output logic [3:0] chanHiZ,
    output logic [7:0] chanGain,
    output logic gainFold,
    output logic [1:0] dcThreshold,
    // Pins and identity
    output logic faultN,
    output logic clipHeatN,
    output logic busHiZ,
    output logic [6:0] slaveAddr,
    output logic oscMaster
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Shutdown must not pass the upper end of the allowed window and must fit the counter
    if (OC_STOP_CYCLES < 1 || OC_STOP_CYCLES > 65535 ||
            OC_STOP_CYCLES > `APF_OC_STOP_MAX_CYCLES) begin : g_chk
        $error("OC_STOP_CYCLES out of range");
    end
    localparam logic [15:0] OcLimit = 16'(OC_STOP_CYCLES - 1);
    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire clrAll = rst | porActive;  // Power-on reset wipes setup
    wire wrGain = regWrEn & (regAddr == `APF_REG_GAIN);
    wire wrCtrl = regWrEn & (regAddr == `APF_REG_CTRL);
    wire wrDcTime = regWrEn & (regAddr == `APF_REG_DCTIME);
    wire wrMode = regWrEn & (regAddr == `APF_REG_MODE);
    wire wrCmd = regWrEn & (regAddr == `APF_REG_CMD);
    // Channel restart mask and global clear from the command
    wire [3:0] chanClr = wrCmd ? regWrData[3:0] : 4'h0;
    wire globClr = wrCmd & regWrData[`APF_CMD_GLOBAL_BIT];
    // Live conditions that force every channel output to high impedance
    wire supplyBad = powerStageLow | analogSupplyLow | chargePumpLow | powerStageHigh;
    wire forceAll = tempShutdown | supplyBad;
    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] gain_q;       // Two bits per channel
    logic [1:0] clipSrc_q;    // Indicator source
    logic dcSdEn_q;           // Stop channel on dc event
    logic [1:0] dcTh_q;       // Dc level to the comparator
    logic [7:0] dcTime_q;     // Dc duration in 256-cycle steps
    logic [3:0] mode_q;       // Mute (high impedance) per channel
    logic [3:0] mode_d;
    // Live supply and thermal faults force mute; set beats the software write
    assign mode_d = forceAll ? 4'hF : wrMode ? regWrData[3:0] : (mode_q & ~chanClr);
    // Configuration writes; reset keeps thermal warning on the pin
    always_ff @(posedge sys_clk) begin
        if (clrAll) begin
            gain_q <= `APF_GAIN_RST;
            clipSrc_q <= `APF_CLIPSRC_RST;
            dcSdEn_q <= 1'b0;  // Dc stop off by default
            dcTh_q <= 2'h0;
            dcTime_q <= `APF_DCTIME_RST;
            mode_q <= `APF_MODE_RST;
        end else begin
            if (wrGain) gain_q <= regWrData;
            if (wrCtrl) begin
                clipSrc_q <= regWrData[1:0];
                dcSdEn_q <= regWrData[`APF_CTRL_DCSD_BIT];
                dcTh_q <= regWrData[`APF_CTRL_DCTH_LSB +: 2];
            end
            if (wrDcTime) dcTime_q <= regWrData;
            mode_q <= mode_d;
        end
    end
    // ----------------------------------------
    // Per-channel protection
    // ----------------------------------------
    wire [3:0] ocStop;    // Latched overcurrent stop
    wire [3:0] dcEvt;     // Latched dc event
    wire [3:0] chanStop;  // Channel held in high impedance
    wire [15:0] dcLimit = {dcTime_q, 8'hFF};
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [15:0] ocCnt_q;
        logic [15:0] dcCnt_q;
        logic ocStop_q;
        logic dc_q;
        // Stop immediately on mute, a latched short, an enabled dc event or a live fault
        assign chanStop[i] = mode_q[i] | ocStop_q | (dc_q & dcSdEn_q) | forceAll;
        wire ocRun = peakOverCur[i] & ~chanStop[i];
        wire ocHit = ocRun & (ocCnt_q == OcLimit);
        wire dcRun = dcOffsetHigh[i] & ~chanStop[i];
        wire dcHit = dcRun & (dcCnt_q == dcLimit);
        // Short counter restarts whenever the short lets go
        always_ff @(posedge sys_clk) begin
            if (clrAll) begin
                ocCnt_q <= 16'h0000;
                dcCnt_q <= 16'h0000;
                ocStop_q <= 1'b0;
                dc_q <= 1'b0;
            end else begin
                ocCnt_q <= (ocRun & ~ocHit) ? ocCnt_q + 16'h0001 : 16'h0000;
                dcCnt_q <= (dcRun & ~dcHit) ? dcCnt_q + 16'h0001 : 16'h0000;
                // Set wins over the clear command
                ocStop_q <= ocHit | (ocStop_q & ~chanClr[i]);
                dc_q <= dcHit | (dc_q & ~chanClr[i]);
            end
        end
        assign ocStop[i] = ocStop_q;
        assign dcEvt[i] = dc_q;
        // Gain drops one step under foldback; the lowest step stays put
        wire [1:0] g = gain_q[2*i +: 2];
        assign chanGain[2*i +: 2] = (tempFoldback && g != 2'h0) ? g - 2'h1 : g;
        // Assertions for the channel
        sequence s_short_held;
            ocRun && ocCnt_q == OcLimit;
        endsequence
        a_oc_stop_time: assert property (@(posedge sys_clk) disable iff (clrAll)
            s_short_held |=> ocStop_q ##1 chanHiZ[i]) else $error("short not shut down");
        a_short_brief: assert property (@(posedge sys_clk) disable iff (clrAll)
            !peakOverCur[i] && !ocStop_q && !chanClr[i] |=> !ocStop_q && ocCnt_q == 16'h0000)
            else $error("brief short latched");
        a_cut_pulse: assert property (@(posedge sys_clk) disable iff (clrAll)
            avgOverCur[i] && !chanStop[i] |=> pulseEnd[i]) else $error("pulse not cut");
        a_restart: assert property (@(posedge sys_clk) disable iff (clrAll)
            chanClr[i] && !ocHit && !dcHit && !forceAll && !wrMode |=> !chanStop[i])
            else $error("restart failed");
        a_dc_stop: assert property (@(posedge sys_clk) disable iff (clrAll)
            dcHit && dcSdEn_q |=> ##1 chanHiZ[i] && !faultN) else $error("dc stop missing");
    end
    // ----------------------------------------
    // Global fault latches
    // ----------------------------------------
    logic thermSd_q;       // Thermal shutdown seen
    logic [2:0] supLow_q;  // Power stage, analog, charge pump low
    logic supHigh_q;       // Power stage high
    logic [2:0] warn_q;    // Warning levels with hysteresis
    // Latch faults until the global clear; set wins
    always_ff @(posedge sys_clk) begin
        if (clrAll) begin
            thermSd_q <= 1'b0;
            supLow_q <= 3'h0;
            supHigh_q <= 1'b0;
            warn_q <= 3'h0;
        end else begin
            thermSd_q <= tempShutdown | (thermSd_q & ~globClr);
            supLow_q <= {chargePumpLow, analogSupplyLow, powerStageLow} |
                (supLow_q & {3{~globClr}});
            supHigh_q <= powerStageHigh | (supHigh_q & ~globClr);
            // Clears only once below the lower edge
            warn_q <= tempAbove | (warn_q & ~tempBelowHyst);
        end
    end
    // ----------------------------------------
    // Pins and outputs
    // ----------------------------------------
    // Dc events count only when their stop is enabled
    wire faultAny = |ocStop | (|dcEvt & dcSdEn_q) | thermSd_q | |supLow_q | supHigh_q;
    wire clipAny = |fullDuty;  // One pin for all channels
    wire tweetAny = |tweetDetect;
    logic clipSel;
    always_comb begin
        case (apf_clip_src_t'(clipSrc_q))
            SRC_CLIP: clipSel = clipAny;
            SRC_WARN: clipSel = warn_q[0];
            SRC_BOTH: clipSel = clipAny | warn_q[0];
            SRC_TWEET: clipSel = tweetAny;
            default: clipSel = 1'b0;
        endcase
    end
    // Status register contents
    wire [7:0] fault0 = {supLow_q[2], supLow_q[1], supLow_q[0], thermSd_q, ocStop};
    wire [7:0] fault1 = {3'h0, supHigh_q, dcEvt};
    wire [7:0] therm = {warn_q, tempFoldback, tempShutdown, 3'h0};
    wire [7:0] ctrlRd = {3'h0, dcTh_q, dcSdEn_q, clipSrc_q};
    wire [7:0] modeRd = {chanStop, mode_q};
    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            `APF_REG_FAULT0: rdMux = fault0;
            `APF_REG_FAULT1: rdMux = fault1;
            `APF_REG_THERM: rdMux = therm;
            `APF_REG_GAIN: rdMux = gain_q;
            `APF_REG_CTRL: rdMux = ctrlRd;
            `APF_REG_DCTIME: rdMux = dcTime_q;
            `APF_REG_MODE: rdMux = modeRd;
            default: rdMux = 8'h00;  // Unmapped and command read as zero
        endcase
    end
    logic [1:0] addr_q;  // Strap resampled every cycle once reset is released
    // Registered outputs; each starts quiet, channels start muted
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
            pulseEnd <= 4'h0;
            chanHiZ <= 4'hF;
            faultN <= 1'b1;
            clipHeatN <= 1'b1;
            busHiZ <= 1'b1;
            addr_q <= 2'h0;
            switchRef <= 1'b0;
        end else begin
            regRdData <= regRdEn ? rdMux : regRdData;
            pulseEnd <= (avgOverCur | peakOverCur) & ~chanStop;
            chanHiZ <= chanStop;
            faultN <= ~faultAny;
            clipHeatN <= ~clipSel;
            busHiZ <= porActive;
            addr_q <= addrSel;
            // Slave follows align pin, master its own oscillator
            switchRef <= (addr_q == 2'h0) ? oscLocal : oscAlignIn;
        end
    end
    assign slaveAddr = `APF_ADDR_BASE | {5'h00, addr_q};
    assign oscMaster = (addr_q == 2'h0);
    assign oscAlignOe = oscMaster;  // Master drives the align pin
    assign oscAlignOut = oscLocal;
    assign gainFold = tempFoldback;
    assign dcThreshold = dcTh_q;
    // ----------------------------------------
    // Global assertions
    // ----------------------------------------
    a_fault_pin: assert property (@(posedge sys_clk) disable iff (clrAll)
        $rose(|ocStop) |=> !faultN) else $error("fault pin late");
    a_clip_pin: assert property (@(posedge sys_clk) disable iff (clrAll)
        clipSrc_q == SRC_CLIP && clipAny |=> !clipHeatN) else $error("clip missed");
    a_therm_sd: assert property (@(posedge sys_clk) disable iff (clrAll)
        tempShutdown |=> chanHiZ == 4'hF && mode_q == 4'hF ##1 !faultN)
        else $error("thermal stop missing");
    a_warn_hold: assert property (@(posedge sys_clk) disable iff (clrAll)
        warn_q[0] && !tempBelowHyst[0] |=> warn_q[0]) else $error("warning dropped");
    a_supply_low: assert property (@(posedge sys_clk) disable iff (clrAll)
        powerStageLow |=> supLow_q[0] ##1 !faultN) else $error("supply low missed");
    a_supply_high: assert property (@(posedge sys_clk) disable iff (clrAll)
        powerStageHigh |=> fault1[4] && chanHiZ == 4'hF) else $error("supply high missed");
    a_fold_gain: assert property (@(posedge sys_clk) disable iff (clrAll)
        tempFoldback && gain_q[1:0] == 2'h3 |-> chanGain[1:0] == 2'h2)
        else $error("foldback no effect");
endmodule : apf_monitor

// *** apf_monitor_test.sv ***
// Purpose: Self-checking bench of the protection and fault monitor
// Assumes: Overcurrent count shortened to 8 cycles
// Notes:   All inputs change on the falling edge
`timescale 1ns/10ps
module apf_monitor_test import apf_pkg::*; ;
    localparam int StopCycles = 8; // Short count keeps the run brief
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic regWrEn, regRdEn, oscLocal, oscAlignIn, oscAlignOut, oscAlignOe, switchRef;
    logic [7:0] regAddr, regWrData, regRdData, rdv, chanGain;
    logic [3:0] avgOverCur, peakOverCur, dcOffsetHigh, fullDuty, tweetDetect;
    logic [3:0] pulseEnd, chanHiZ;
    logic [2:0] tempAbove, tempBelowHyst;
    logic tempShutdown, tempFoldback, porActive;
    logic powerStageLow, analogSupplyLow, chargePumpLow, powerStageHigh;
    logic gainFold, faultN, clipHeatN, busHiZ, oscMaster;
    logic [1:0] addrSel, dcThreshold;
    logic [6:0] slaveAddr;
    int badCount = 0;
    int checked = 0;
    int cycles = 0;

    apf_monitor #(.OC_STOP_CYCLES(StopCycles)) dut (.sys_clk, .rst, .regWrEn, .regRdEn,
        .regAddr, .regWrData, .regRdData, .avgOverCur, .peakOverCur, .dcOffsetHigh, .fullDuty,
        .tweetDetect, .tempAbove, .tempBelowHyst, .tempShutdown, .tempFoldback, .powerStageLow,
        .analogSupplyLow, .chargePumpLow, .powerStageHigh, .porActive, .addrSel, .oscLocal,
        .oscAlignIn, .oscAlignOut, .oscAlignOe, .switchRef, .pulseEnd, .chanHiZ, .chanGain,
        .gainFold, .dcThreshold, .faultN, .clipHeatN, .busHiZ, .slaveAddr, .oscMaster);
    apf_host_model host (.sys_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData);

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    always #2.5 sys_clk = ~sys_clk;

    // Hang guard, well above the fewer than one thousand cycles expected
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            badCount++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Quiet sense levels: cool die, good supplies
    task automatic idle();
        {avgOverCur, peakOverCur, dcOffsetHigh, fullDuty, tweetDetect} = '0;
        {tempAbove, tempShutdown, tempFoldback} = '0;
        tempBelowHyst = 3'h7;
        {powerStageLow, analogSupplyLow, chargePumpLow, powerStageHigh, porActive} = '0;
    endtask : idle

    // Strap is sampled when reset lets go
    task automatic do_reset(input logic [1:0] sel);
        @(negedge sys_clk);
        rst = 1'b1;
        addrSel = sel;
        tick(16);
        rst = 1'b0;
        tick(2);
    endtask : do_reset

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        host.rd(8'h0A, rdv);
        chk("clip source", 8'h01, rdv);
        host.rd(8'h0B, rdv);
        chk("dc time", 8'h10, rdv);
        host.rd(8'h07, rdv);
        chk("unmapped", 8'h00, rdv);
        host.wr(8'h04, 8'hFF);
        host.rd(8'h04, rdv);
        chk("status locked", 8'h00, rdv);
        chk("muted", 4'hF, chanHiZ);
        chk("fault pin", 1'b1, faultN);
        chk("bus on", 1'b0, busHiZ);
        chk("address", 7'h6C, slaveAddr);
        chk("master", 1'b1, oscMaster & oscAlignOe & oscAlignOut & switchRef);
        host.wr(8'h0C, 8'h00);
        tick(2);
        chk("unmuted", 4'h0, chanHiZ);
    endtask : t_defaults

    task automatic t_current();
        avgOverCur = 4'h1;
        tick(3);
        chk("pulse end", 4'h1, pulseEnd);
        chk("still playing", 4'h0, chanHiZ);
        avgOverCur = 4'h0;
        peakOverCur = 4'h4;
        tick(StopCycles / 2);
        chk("peak limit", 4'h4, pulseEnd);
        peakOverCur = 4'h0;
        tick(12);
        chk("brief short", 8'h10, {3'h0, faultN, chanHiZ});
        peakOverCur = 4'h2;
        tick(StopCycles + 4);
        chk("short stop", 4'h2, chanHiZ);
        peakOverCur = 4'h0;
        tick(3);
        host.rd(8'h00, rdv);
        chk("oc bit", 8'h02, rdv);
        chk("oc pin", 1'b0, faultN);
        host.wr(8'h0D, 8'h02);
        tick(2);
        chk("restart", 8'h10, {3'h0, faultN, chanHiZ});
    endtask : t_current

    task automatic t_dc();
        host.wr(8'h0B, 8'h00);
        dcOffsetHigh = 4'h1;
        tick(270);
        chk("dc no stop", 8'h10, {3'h0, faultN, chanHiZ});
        host.rd(8'h01, rdv);
        chk("dc event", 8'h01, rdv);
        dcOffsetHigh = 4'h0;
        host.wr(8'h0D, 8'h01);
        host.wr(8'h0A, 8'h1D);
        chk("dc level", 2'h3, dcThreshold);
        dcOffsetHigh = 4'h4;
        tick(270);
        chk("dc stop", 8'h04, {3'h0, faultN, chanHiZ});
        dcOffsetHigh = 4'h0;
        host.wr(8'h0D, 8'h04);
        tick(2);
        chk("dc clear", 8'h10, {3'h0, faultN, chanHiZ});
    endtask : t_dc

    task automatic t_clip();
        logic exp;
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h0A, {6'h00, apf_clip_src_t'(s)});
            for (int k = 0; k < 3; k++) begin
                fullDuty = (k == 0) ? 4'h8 : 4'h0;
                tempAbove = (k == 1) ? 3'h1 : 3'h0;
                tempBelowHyst = (k == 1) ? 3'h6 : 3'h7;
                tweetDetect = (k == 2) ? 4'h2 : 4'h0;
                tick(3);
                exp = (s == 3) ? (k == 2) : (s == 2) ? (k < 2) : (k == s);
                chk("clip pin", !exp, clipHeatN);
            end
        end
        idle();
        tick(3);
        chk("clip gone", 1'b1, clipHeatN);
    endtask : t_clip

    task automatic t_thermal();
        host.wr(8'h0A, 8'h01);
        tempAbove = 3'h7;
        tempBelowHyst = 3'h0;
        tick(3);
        host.rd(8'h04, rdv);
        chk("warn levels", 8'hE0, rdv);
        chk("warn pin", 1'b0, clipHeatN);
        tempAbove = 3'h0;
        tick(3);
        host.rd(8'h04, rdv);
        chk("hysteresis", 8'hE0, rdv);
        tempBelowHyst = 3'h7;
        tick(3);
        host.rd(8'h04, rdv);
        chk("cooled", 8'h00, rdv);
        chk("cooled pin", 1'b1, clipHeatN);
        tempShutdown = 1'b1;
        tick(1);
        chk("heat stop", 4'hF, chanHiZ);
        tick(1);
        chk("heat pin", 1'b0, faultN);
        host.rd(8'h00, rdv);
        chk("heat bit", 8'h10, rdv);
        host.rd(8'h04, rdv);
        chk("heat live", 8'h08, rdv);
        tempShutdown = 1'b0;
        host.wr(8'h0D, 8'h10);
        host.wr(8'h0C, 8'h00);
        tick(2);
        chk("heat restart", 8'h10, {3'h0, faultN, chanHiZ});
    endtask : t_thermal

    task automatic t_supply();
        for (int i = 0; i < 4; i++) begin
            {powerStageHigh, chargePumpLow, analogSupplyLow, powerStageLow} = 4'(1 << i);
            tick(1);
            chk("supply stop", 4'hF, chanHiZ);
            tick(1);
            chk("supply pin", 1'b0, faultN);
            {powerStageHigh, chargePumpLow, analogSupplyLow, powerStageLow} = 4'h0;
            host.rd((i == 3) ? 8'h01 : 8'h00, rdv);
            chk("supply bit", (i == 3) ? 8'h10 : 8'(8'h20 << i), rdv);
            host.wr(8'h0D, 8'h10);
            host.wr(8'h0C, 8'h00);
            tick(2);
            chk("supply clear", 8'h10, {3'h0, faultN, chanHiZ});
        end
    endtask : t_supply

    task automatic t_gain_por();
        host.wr(8'h05, 8'hE7);
        tick(1);
        chk("gain", 8'hE7, chanGain);
        tempFoldback = 1'b1;
        tick(1);
        chk("folded", 8'h92, chanGain);
        chk("fold flag", 1'b1, gainFold);
        tempFoldback = 1'b0;
        porActive = 1'b1;
        tick(2);
        chk("bus off", 1'b1, busHiZ);
        porActive = 1'b0;
        tick(2);
        host.rd(8'h05, rdv);
        chk("gain lost", 8'h00, rdv);
    endtask : t_gain_por

    task automatic t_address();
        for (int i = 1; i < 4; i++) begin
            do_reset(2'(i));
            chk("slave addr", {1'b0, 7'h6C | 7'(i)}, {oscMaster, slaveAddr});
        end
        oscAlignIn = 1'b1;
        oscLocal = 1'b0;
        tick(2);
        chk("follow align", {oscAlignOe, switchRef}, 2'b01);
    endtask : t_address

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        idle();
        addrSel = 2'h0;
        oscLocal = 1'b1;
        oscAlignIn = 1'b0;
        do_reset(2'h0);
        t_defaults();
        t_current();
        t_dc();
        t_clip();
        t_thermal();
        t_supply();
        t_gain_por();
        t_address();
        wrap_up();
    end
endmodule : apf_monitor_test

// *** apf_pkg.sv ***
// Purpose: Types of the amplifier protection and fault monitor
// Assumes: Nothing beyond the config header
// Notes:   Constants live in apf_cfg.svh
package apf_pkg;
    // Source of the clip/heat indicator pin
    typedef enum logic [1:0] {
        SRC_CLIP = 2'b00,
        SRC_WARN = 2'b01,
        SRC_BOTH = 2'b10,
        SRC_TWEET = 2'b11
    } apf_clip_src_t;
endpackage : apf_pkg
